// ---- design/hfs_pgood.sv ----
// Power-good delay and open-drain drive
`timescale 1ns/1ps
`default_nettype none
module hfs_pgood (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Conditions
  input wire logic enable_in,
  input wire logic thermal_in,
  input wire logic above_upper_in,
  input wire logic below_lower_in,
  input wire logic cycle_start_in,
  // Open-drain pin, enable high pulls low
  output logic pgood_oe_out
);
  logic [hfs_pkg::PGOOD_W-1:0] cnt_ff;
  logic [hfs_pkg::PGOOD_W-1:0] nxt_cnt;
  logic oe_ff;
  logic nxt_oe;

  // Delay counts switching cycles while above the upper threshold
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_oe = oe_ff;
    if (!enable_in || thermal_in || below_lower_in)
    begin
      nxt_cnt = '0;
      nxt_oe = 1'b1;
    end
    else if (oe_ff && above_upper_in && cycle_start_in)
    begin
      if (cnt_ff == hfs_pkg::PGOOD_LAST)
        nxt_oe = 1'b0;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
    else if (oe_ff && !above_upper_in)
      nxt_cnt = '0; // Restart delay if output sags into the band
  end

  // Pin pulled low from reset so the observer sees not-good
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= '0;
      oe_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      oe_ff <= nxt_oe;
    end
  end

  assign pgood_oe_out = oe_ff;
endmodule
`default_nettype wire

// ---- design/hfs_sequencer.sv ----
// Protection and hiccup sequencer for an iso-buck power stage
`timescale 1ns/1ps
`default_nettype none
module hfs_sequencer (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Configuration, high selects the enhanced variant
  input wire logic enhanced_in,
  // Comparator flags, synchronous to the clock
  input wire logic enable_undervoltage_input_in,
  input wire logic cycle_start_in,
  input wire logic peak_limit_in,
  input wire logic sink_limit_in,
  input wire logic runaway_limit_in,
  input wire logic neg_discharge_limit_in,
  input wire logic pri_undervoltage_in,
  input wire logic pri_above_upper_in,
  input wire logic pri_below_lower_in,
  input wire logic soft_start_done_in,
  input wire logic thermal_in,
  // Switch drivers and soft-start control
  output logic high_side_switch_out,
  output logic low_side_switch_out,
  output logic ss_discharge_out,
  // Open-drain power-good pin: enable high drives low
  output logic pgood_out,
  output logic pgood_oe_out,
  // Status
  output logic hiccup_out
);
  // Sequencer state and hiccup timeout
  hfs_pkg::hfs_state_t state_ff;
  hfs_pkg::hfs_state_t nxt_state;
  logic [hfs_pkg::HICCUP_W-1:0] tmo_ff;
  logic [hfs_pkg::HICCUP_W-1:0] nxt_tmo;

  // Run of switching cycles that saw a sink-limit event
  logic [hfs_pkg::NEG_W-1:0] neg_ff;
  logic [hfs_pkg::NEG_W-1:0] nxt_neg;
  logic neg_seen_ff;
  logic nxt_neg_seen;

  // Registered drives, so no comparator glitch reaches a gate driver
  logic hs_ff;
  logic nxt_hs;
  logic ls_ff;
  logic nxt_ls;
  logic ssd_ff;
  logic nxt_ssd;
  logic hic_ff;
  logic nxt_hic;

  // Decoded conditions
  logic neg_trip;
  logic trigger;
  logic en;

  assign en = enable_undervoltage_input_in;

  // Sixteenth consecutive negative-limit cycle, enhanced only
  assign neg_trip = enhanced_in && cycle_start_in && neg_seen_ff
    && (neg_ff == hfs_pkg::NEG_RUN_LAST);

  // Hiccup triggers common to both variants plus the enhanced run
  assign trigger = runaway_limit_in || neg_trip
    || (pri_undervoltage_in && (state_ff == hfs_pkg::HFS_RUN));

  // Sequencer state, timeout and negative-run counters
  always_comb
  begin
    nxt_state = state_ff;
    nxt_tmo = tmo_ff;
    nxt_neg = neg_ff;
    // A cycle counts toward the run if any sink event fell inside it
    nxt_neg_seen = neg_seen_ff || sink_limit_in;
    if (cycle_start_in)
    begin
      nxt_neg_seen = sink_limit_in;
      if (neg_seen_ff)
        nxt_neg = neg_ff + 1'b1;
      else
        nxt_neg = '0;
    end
    // Disable acts as a synchronous clear of the whole sequence
    if (!en)
    begin
      nxt_state = hfs_pkg::HFS_OFF;
      nxt_tmo = '0;
      nxt_neg = '0;
      nxt_neg_seen = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        hfs_pkg::HFS_OFF:
        begin
          // A hot die waits in thermal shutdown instead of starting
          if (thermal_in)
            nxt_state = hfs_pkg::HFS_THERMAL;
          else
            nxt_state = hfs_pkg::HFS_SOFT_START;
        end
        hfs_pkg::HFS_SOFT_START, hfs_pkg::HFS_RUN:
        begin
          if (thermal_in)
            nxt_state = hfs_pkg::HFS_THERMAL;
          else if (trigger)
          begin
            nxt_state = hfs_pkg::HFS_HICCUP;
            nxt_tmo = '0;
            nxt_neg = '0;
            nxt_neg_seen = 1'b0;
          end
          else if (state_ff == hfs_pkg::HFS_SOFT_START && soft_start_done_in)
            nxt_state = hfs_pkg::HFS_RUN;
        end
        hfs_pkg::HFS_HICCUP:
        begin
          // No run can build up while switching is suspended
          nxt_neg = '0;
          nxt_neg_seen = 1'b0;
          if (tmo_ff == hfs_pkg::HICCUP_LAST)
            nxt_state = hfs_pkg::HFS_SOFT_START;
          else
            nxt_tmo = tmo_ff + 1'b1;
        end
        hfs_pkg::HFS_THERMAL:
          if (!thermal_in)
            nxt_state = hfs_pkg::HFS_SOFT_START;
      endcase
    end
  end

  // Switch enables and soft-start discharge
  always_comb
  begin
    nxt_hs = 1'b0;
    nxt_ls = 1'b0;
    nxt_ssd = 1'b1;
    // Status follows the state being entered, in step with the drives
    nxt_hic = (nxt_state == hfs_pkg::HFS_HICCUP);
    unique case (nxt_state)
      hfs_pkg::HFS_SOFT_START, hfs_pkg::HFS_RUN:
      begin
        nxt_ssd = 1'b0;
        // High side closes each cycle, opens on peak or runaway limit;
        // a limit flag wins even on the cycle-start clock
        if ((cycle_start_in || hs_ff) && !peak_limit_in && !runaway_limit_in)
          nxt_hs = 1'b1;
        nxt_ls = !nxt_hs && !sink_limit_in;
      end
      hfs_pkg::HFS_HICCUP:
      begin
        // Enhanced discharge: low side on each cycle until the limit trips;
        // the sink limit still overrides, as in normal switching
        if (enhanced_in && !neg_discharge_limit_in && !sink_limit_in)
          nxt_ls = cycle_start_in || ls_ff;
      end
      hfs_pkg::HFS_OFF, hfs_pkg::HFS_THERMAL:
      begin
        // Both switches stay off and the soft-start capacitor is drained
        nxt_ssd = 1'b1;
      end
      default:
        nxt_ssd = 1'b1; // Unused codes fall back to the safe, drained state
    endcase
  end

  // Register all state; switches off from reset
  // Reset values match the disabled state, so release starts cleanly
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= hfs_pkg::HFS_OFF;
      tmo_ff <= '0;
      neg_ff <= '0;
      neg_seen_ff <= 1'b0;
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      ssd_ff <= 1'b1;
      hic_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmo_ff <= nxt_tmo;
      neg_ff <= nxt_neg;
      neg_seen_ff <= nxt_neg_seen;
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
      ssd_ff <= nxt_ssd;
      hic_ff <= nxt_hic;
    end
  end

  // Power-good delay lives in its own counter block
  // It sees the same enable, so a disable also restarts the delay
  hfs_pgood u_pgood (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .enable_in(en),
    .thermal_in(thermal_in),
    .above_upper_in(pri_above_upper_in),
    .below_lower_in(pri_below_lower_in),
    .cycle_start_in(cycle_start_in),
    .pgood_oe_out(pgood_oe_out)
  );

  // Every drive pin comes straight from its register
  assign high_side_switch_out = hs_ff;
  assign low_side_switch_out = ls_ff;
  assign ss_discharge_out = ssd_ff;
  assign hiccup_out = hic_ff;
  // Open-drain: only ever drives zero; validity is the observer's
  assign pgood_out = 1'b0;
endmodule
`default_nettype wire

// ---- include/hfs_pkg.sv ----
// Package of constants for the hiccup fault sequencer
package hfs_pkg;
  localparam int unsigned HICCUP_CYCLES = 32768;
  localparam int unsigned PGOOD_DELAY_CYCLES = 1024;
  localparam int unsigned NEG_RUN_LIMIT = 16;
  localparam int unsigned HICCUP_W = 16;
  localparam int unsigned PGOOD_W = 11;
  localparam int unsigned NEG_W = 5;
  localparam logic [HICCUP_W-1:0] HICCUP_LAST = HICCUP_W'(HICCUP_CYCLES - 1);
  localparam logic [PGOOD_W-1:0] PGOOD_LAST = PGOOD_W'(PGOOD_DELAY_CYCLES - 1);
  localparam logic [NEG_W-1:0] NEG_RUN_LAST = NEG_W'(NEG_RUN_LIMIT - 1);
  typedef enum logic [2:0] {
    HFS_OFF,
    HFS_SOFT_START,
    HFS_RUN,
    HFS_HICCUP,
    HFS_THERMAL
  } hfs_state_t;
endpackage

// ---- tb/hfs_sequencer_props.sv ----
// Port assertions for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module hfs_sequencer_props (
  // Watched ports
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic enable_undervoltage_input_in,
  input wire logic peak_limit_in,
  input wire logic sink_limit_in,
  input wire logic runaway_limit_in,
  input wire logic pri_below_lower_in,
  input wire logic thermal_in,
  input wire logic high_side_switch_out,
  input wire logic low_side_switch_out,
  input wire logic ss_discharge_out,
  input wire logic pgood_oe_out,
  input wire logic hiccup_out
);
  logic en;
  int hic_ff;
  int nxt_hic;
  assign en = enable_undervoltage_input_in;
  // Length of the current hiccup timeout
  always_comb
    nxt_hic = hiccup_out ? hic_ff + 1 : 0;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      hic_ff <= 0;
    else
      hic_ff <= nxt_hic;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Three enabled cool cycles leave the off state behind
  sequence active_s;
    (en && !thermal_in)[*3];
  endsequence
  off_switch_a: assert property (!en |=> !high_side_switch_out && !low_side_switch_out)
    else $error("switch on while off");
  off_drain_a: assert property (!en |=> ss_discharge_out && pgood_oe_out)
    else $error("no drain while off");
  peak_cut_a: assert property (peak_limit_in |=> !high_side_switch_out)
    else $error("peak not cut");
  sink_cut_a: assert property (sink_limit_in |=> !low_side_switch_out)
    else $error("sink not cut");
  runaway_trip_a: assert property (active_s ##0 (runaway_limit_in && !hiccup_out) |=> hiccup_out)
    else $error("runaway missed");
  hiccup_high_a: assert property (hiccup_out |-> !high_side_switch_out)
    else $error("high side on in hiccup");
  hiccup_len_a: assert property ($fell(hiccup_out) && $past(en) |-> hic_ff == hfs_pkg::HICCUP_CYCLES)
    else $error("hiccup length");
  pgood_low_a: assert property (pri_below_lower_in || thermal_in |=> pgood_oe_out)
    else $error("power-good not low");
endmodule
bind hfs_sequencer hfs_sequencer_props hfs_sequencer_props_i (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .enable_undervoltage_input_in(enable_undervoltage_input_in),
  .peak_limit_in(peak_limit_in),
  .sink_limit_in(sink_limit_in),
  .runaway_limit_in(runaway_limit_in),
  .pri_below_lower_in(pri_below_lower_in),
  .thermal_in(thermal_in),
  .high_side_switch_out(high_side_switch_out),
  .low_side_switch_out(low_side_switch_out),
  .ss_discharge_out(ss_discharge_out),
  .pgood_oe_out(pgood_oe_out),
  .hiccup_out(hiccup_out)
);
`default_nettype wire

// ---- tb/hfs_stage_model.sv ----
// Behavioural power stage: cycle clock and current comparators
`timescale 1ns/1ps
`default_nettype none
module hfs_stage_model (
  // Clock, reset and switch drives
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hs_in,
  input wire logic ls_in,
  input wire logic sink_req_in,
  // Comparator flags
  output logic cycle_start_out,
  output logic peak_out,
  output logic sink_out,
  output logic neg_out
);
  logic [1:0] cnt_ff;
  // Currents trip one clock after a switch closes; sink trips only when asked
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      {cnt_ff, peak_out, sink_out, neg_out} <= 5'h0;
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      peak_out <= hs_in;
      sink_out <= ls_in && sink_req_in;
      neg_out <= ls_in;
    end
  // One switching cycle every four clocks
  assign cycle_start_out = (cnt_ff == 2'h0);
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic en, th, ss, oe;} hfs_row_t;
  hfs_row_t rows[3] = '{'{0, 0, 1, 1}, '{1, 1, 1, 1}, '{1, 0, 0, 1}};
  logic clk, rst, enh, en, run, uv, up, lo, ssd, th, sr, cs, pk, sk, ng, hs, ls, sd, oe, hic;
  int err_total, n_checks, n, k;
  hfs_sequencer hfs_sequencer_i (.core_clk_in(clk), .rst_in(rst), .enhanced_in(enh),
    .enable_undervoltage_input_in(en), .cycle_start_in(cs), .peak_limit_in(pk),
    .sink_limit_in(sk), .runaway_limit_in(run), .neg_discharge_limit_in(ng),
    .pri_undervoltage_in(uv), .pri_above_upper_in(up), .pri_below_lower_in(lo),
    .soft_start_done_in(ssd), .thermal_in(th), .high_side_switch_out(hs),
    .low_side_switch_out(ls), .ss_discharge_out(sd), .pgood_out(), .pgood_oe_out(oe),
    .hiccup_out(hic));
  hfs_stage_model hfs_stage_model_i (.clk_in(clk), .rst_in(rst), .hs_in(hs), .ls_in(ls),
    .sink_req_in(sr), .cycle_start_out(cs), .peak_out(pk), .sink_out(sk), .neg_out(ng));
  // Core clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Outputs are read at the falling edge, well clear of updates
  task automatic edges(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Two full hiccup timeouts dominate the run time
  initial
  begin
    repeat (90000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {enh, en, run, uv, up, lo, ssd, th, sr} = 9'h0;
    rst = 1;
    edges(3);
    check(hs | ls | hic, 0, "reset outputs");
    check(sd & oe, 1, "reset drain");
    repeat (3) @(posedge clk);
    rst <= 0;
    foreach (rows[i])
    begin
      @(posedge clk);
      en <= rows[i].en;
      th <= rows[i].th;
      edges(3);
      check(sd, rows[i].ss, "discharge");
      check(oe, rows[i].oe, "pgood drive");
    end
    $display("table done");
    @(posedge clk);
    {ssd, up} <= 2'h3;
    for (n = 0, k = 0; oe === 1'b1 && k < 6000; k++)
    begin
      @(negedge clk);
      n += cs;
    end
    check(n == 1024, 1, "pgood delay");
    @(posedge clk);
    lo <= 1;
    edges(2);
    check(oe, 1, "pgood drop");
    @(posedge clk);
    {lo, run} <= 2'h1;
    @(posedge clk);
    run <= 0;
    edges(1);
    check(hic, 1, "runaway trip");
    for (k = 0; hic === 1'b1 && k < 40000; k++)
    begin
      @(negedge clk);
      if (k == 9)
        check(hs | ls, 0, "basic idle");
    end
    check(k == 32768, 1, "timeout");
    check(sd, 0, "retry");
    edges(3);
    @(posedge clk);
    uv <= 1;
    edges(2);
    check(hic, 1, "undervoltage trip");
    @(posedge clk);
    {uv, en} <= 2'h0;
    edges(2);
    check(hic | hs, 0, "disable clears");
    check(sd & oe, 1, "disable drains");
    $display("basic done");
    @(posedge clk);
    {enh, en, sr} <= 3'h7;
    repeat (56) @(posedge clk);
    sr <= 0;
    edges(1);
    check(hic, 0, "short run");
    repeat (8) @(posedge clk);
    sr <= 1;
    for (k = 0; hic !== 1'b1 && k < 100; k++)
      @(negedge clk);
    check(hic === 1'b1 && k >= 60, 1, "negative run");
    @(posedge clk);
    sr <= 0;
    for (n = 0; hic === 1'b1 && k < 40000; k++)
    begin
      @(negedge clk);
      n += ls;
    end
    check(n > 0, 1, "active discharge");
    check(hic, 0, "enhanced retry");
    check(sd, 0, "enhanced soft-start");
    $display("enhanced done");
    // Mid-run reset: outputs fall back at once, then a clean restart
    @(posedge clk);
    rst <= 1;
    edges(1);
    check(hs | ls | hic, 0, "mid reset outputs");
    check(sd & oe, 1, "mid reset drain");
    @(posedge clk);
    rst <= 0;
    edges(3);
    check(sd, 0, "restart");
    $display("reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
